/* inc/dvs_pkg.sv */
`default_nettype none
package dvs_pkg;
  // slave address, special bytes and unmapped read value
  localparam logic [4:0] SLAVE_UPPER = 5'h12;
  localparam logic [7:0] HS_CODE_MASK = 8'hf8;
  localparam logic [7:0] HS_CODE_VAL = 8'h08;
  localparam logic [7:0] RD_UNMAPPED = 8'hff;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LSB_BIT = 4'h7;

  // register selects (reg_select_bits)
  localparam logic [1:0] SEL_FLOOR = 2'h0;
  localparam logic [1:0] SEL_ROOF = 2'h1;
  localparam logic [1:0] SEL_MODE = 2'h2;
  localparam logic [1:0] SEL_RAMP = 2'h3;

  // field positions
  localparam int CONV_BIT = 7;
  localparam int LIGHT_BIT = 6;
  localparam int STEP_MSB = 5;
  localparam int PTR_SEL_MSB = 1;
  localparam int PTR_MSB = 7;
  localparam int FLOOR_OP_BIT = 0;
  localparam int ROOF_OP_BIT = 1;
  localparam int RATE_MSB = 2;
  localparam int STRAT_BIT = 4;
  localparam int TRIG_BIT = 7;
  localparam logic [2:0] RATE_SINGLE = 3'h7;

  // reset values
  localparam logic [1:0] VOLT_TOP_RST = 2'h3;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] RAMP_RST = 8'h17;
  localparam logic [7:0] PTR_RST = 8'h00;

  // synchroniser lanes
  localparam int SY_SCL = 0;
  localparam int SY_SDA = 1;
  localparam int SY_CHIP = 2;
  localparam int SY_LVL = 3;
  localparam int SY_SKIP = 4;
  localparam int SY_LOW = 5;
  localparam int SY_WTOG = 6;
  localparam int SY_HTOG = 7;

  // micro-step interval base
  localparam int CLK_PERIOD_PS = 8000;
  localparam int STEP_TIME_NS = 1000;
  localparam int STEP_BASE_CYCLES = (STEP_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  typedef enum logic [2:0] {
    LS_ADDR = 3'h0,
    LS_REG = 3'h1,
    LS_WDATA = 3'h2,
    LS_RDATA = 3'h3,
    LS_IDLE = 3'h4
  } dvs_link_state_t;
endpackage
`default_nettype wire

/* rtl/dvs_i2c_link.sv */
`timescale 1ns/10ps
`default_nettype none
module dvs_i2c_link #(
  parameter logic [1:0] ADDR_OPTION = 2'h0 // addr_option_bits
) (
  input wire logic scl_clk, // serial clock
  input wire logic nrst, // async reset, active low
  input wire logic clr, // restart request from start/stop
  input wire logic sda_in, // data line level
  input wire logic [7:0] rd_data, // byte sent on reads
  output logic drive_low, // pull data line low
  output logic wr_toggle, // flips per committed byte
  output logic wr_is_ptr, // byte was a register address
  output logic [7:0] wr_byte, // committed byte
  output logic hs_toggle // flips on high-speed code
);
  typedef struct packed {
    dvs_pkg::dvs_link_state_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] tx;
    logic drv;
    logic wtog;
    logic wptr;
    logic [7:0] wbyte;
    logic htog;
  } dvs_link_t;
  dvs_link_t q_reg, q_next;
  logic smp_reg;
  logic [7:0] rx;

  // data sampled in the high period
  always_ff @(posedge scl_clk or negedge nrst) begin
    if (!nrst) begin
      smp_reg <= 1'b1;
    end else begin
      smp_reg <= sda_in;
    end
  end

  // byte engine, steps on falling edges; clr settles long before the edge
  always_comb begin
    q_next = q_reg;
    rx = {q_reg.sh[6:0], smp_reg};
    if (clr) begin
      q_next.st = dvs_pkg::LS_ADDR;
      q_next.cnt = 4'h0;
      q_next.drv = 1'b0;
    end else if (q_reg.cnt != dvs_pkg::BYTE_BITS) begin
      q_next.cnt = q_reg.cnt + 4'h1;
      q_next.sh = rx;
      q_next.drv = 1'b0;
      if (q_reg.st == dvs_pkg::LS_RDATA && q_reg.cnt != dvs_pkg::LSB_BIT) begin
        q_next.drv = ~q_reg.tx[7];
        q_next.tx = {q_reg.tx[6:0], 1'b0};
      end
      if (q_reg.cnt == dvs_pkg::LSB_BIT) begin
        case (q_reg.st)
          dvs_pkg::LS_ADDR: begin
            q_next.drv = (rx[7:1] == {dvs_pkg::SLAVE_UPPER, ADDR_OPTION});
            if ((rx & dvs_pkg::HS_CODE_MASK) == dvs_pkg::HS_CODE_VAL) begin
              q_next.htog = ~q_reg.htog;
            end
          end
          dvs_pkg::LS_REG, dvs_pkg::LS_WDATA: begin
            q_next.drv = 1'b1;
            q_next.wtog = ~q_reg.wtog;
            q_next.wptr = (q_reg.st == dvs_pkg::LS_REG);
            q_next.wbyte = rx;
          end
          default: begin
          end
        endcase
      end
    end else begin
      q_next.cnt = 4'h0;
      q_next.drv = 1'b0;
      case (q_reg.st)
        dvs_pkg::LS_ADDR: begin
          if (!q_reg.drv) begin
            q_next.st = dvs_pkg::LS_IDLE;
          end else if (q_reg.sh[0]) begin
            q_next.st = dvs_pkg::LS_RDATA;
          end else begin
            q_next.st = dvs_pkg::LS_REG;
          end
        end
        dvs_pkg::LS_REG: q_next.st = dvs_pkg::LS_WDATA;
        dvs_pkg::LS_RDATA: begin
          if (smp_reg) begin
            q_next.st = dvs_pkg::LS_IDLE;
          end
        end
        default: begin
        end
      endcase
      if (q_next.st == dvs_pkg::LS_RDATA) begin
        q_next.drv = ~rd_data[7];
        q_next.tx = {rd_data[6:0], 1'b0};
      end
    end
  end

  // link state register
  always_ff @(negedge scl_clk or negedge nrst) begin
    if (!nrst) begin
      q_reg <= '{dvs_pkg::LS_IDLE, 4'h0, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0, 8'h00, 1'b0};
    end else begin
      q_reg <= q_next;
    end
  end

  assign drive_low = q_reg.drv;
  assign wr_toggle = q_reg.wtog;
  assign wr_is_ptr = q_reg.wptr;
  assign wr_byte = q_reg.wbyte;
  assign hs_toggle = q_reg.htog;
endmodule // dvs_i2c_link
`default_nettype wire

/* rtl/dvs_register_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
module dvs_register_ctrl #(
  parameter logic [1:0] ADDR_OPTION = 2'h0, // addr_option_bits
  parameter logic [5:0] FLOOR_STEP_RST = 6'h00, // floor code after reset
  parameter logic [5:0] ROOF_STEP_RST = 6'h00, // roof code after reset
  parameter logic [15:0] STEP_BASE_CYC = 16'(dvs_pkg::STEP_BASE_CYCLES) // micro-step base
) (
  input wire logic mclk, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic ce, // clock enable
  input wire logic scl_clk, // serial clock as link clock
  input wire logic scl_in, // serial clock pin level
  input wire logic sda_in, // data pin level
  output logic sda_out, // data pin drive value
  output logic sda_oe_n, // data pin enable, low drives
  input wire logic chip_on_pin, // chip enable pin
  input wire logic level_select_pin, // floor or roof select
  input wire logic skip_pulsing, // converter switching again
  input wire logic out_low_cmp, // output below threshold
  output logic output_good, // power good
  output logic converter_en, // converter running
  output logic [5:0] vout_code, // applied step code
  output logic light_skip_optimize, // light skip tuning
  output logic forced_fixed, // active fixed-frequency mode
  output logic hs_mode // high-speed timing active
);
  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] s3;
    logic [7:0] floor;
    logic [7:0] roof;
    logic [7:0] mode;
    logic [7:0] ramp;
    logic [7:0] ptr;
    logic [7:0] rd;
    logic clr;
    logic hs;
    logic ramping;
    logic drop;
    logic pg;
    logic en;
    logic fixed;
    logic light;
    logic [5:0] cur;
    logic [15:0] cnt;
  } dvs_state_t;
  dvs_state_t q_reg, q_next;

  logic link_drv;
  logic link_wtog;
  logic link_wptr;
  logic [7:0] link_wbyte;
  logic link_htog;
  logic scl_hi, start_c, stop_c;
  logic wr_evt, hs_evt, chip_rise;
  logic single_c, fixed_c;
  logic [7:0] sel_c;
  logic [5:0] goal_c;

  // read mux with unlisted answer
  function automatic logic [7:0] reg_read(input dvs_state_t s);
    if (s.ptr[dvs_pkg::PTR_MSB:dvs_pkg::PTR_SEL_MSB+1] != '0) begin
      return dvs_pkg::RD_UNMAPPED;
    end
    case (s.ptr[dvs_pkg::PTR_SEL_MSB:0])
      dvs_pkg::SEL_FLOOR: return s.floor;
      dvs_pkg::SEL_ROOF: return s.roof;
      dvs_pkg::SEL_MODE: return s.mode;
      default: return s.ramp;
    endcase
  endfunction

  // cycles between micro-steps
  function automatic logic [15:0] step_cycles(input logic [2:0] rate);
    return STEP_BASE_CYC << rate;
  endfunction

  // serial byte engine on the link clock
  dvs_i2c_link #(
    .ADDR_OPTION(ADDR_OPTION)
  ) u_link (
    .scl_clk(scl_clk),
    .nrst(nrst),
    .clr(q_reg.clr),
    .sda_in(sda_in),
    .rd_data(q_reg.rd),
    .drive_low(link_drv),
    .wr_toggle(link_wtog),
    .wr_is_ptr(link_wptr),
    .wr_byte(link_wbyte),
    .hs_toggle(link_htog)
  );

  // bus events from synchronised pins and toggles
  // s1 only feeds s2; edges are taken between s2 and s3
  assign scl_hi = q_reg.s2[dvs_pkg::SY_SCL] & q_reg.s3[dvs_pkg::SY_SCL];
  assign start_c = scl_hi & q_reg.s3[dvs_pkg::SY_SDA] & ~q_reg.s2[dvs_pkg::SY_SDA];
  assign stop_c = scl_hi & ~q_reg.s3[dvs_pkg::SY_SDA] & q_reg.s2[dvs_pkg::SY_SDA];
  assign wr_evt = q_reg.s2[dvs_pkg::SY_WTOG] ^ q_reg.s3[dvs_pkg::SY_WTOG];
  assign hs_evt = q_reg.s2[dvs_pkg::SY_HTOG] ^ q_reg.s3[dvs_pkg::SY_HTOG];
  assign chip_rise = q_reg.s2[dvs_pkg::SY_CHIP] & ~q_reg.s3[dvs_pkg::SY_CHIP];

  // target and mode selection
  assign sel_c = q_reg.s2[dvs_pkg::SY_LVL] ? q_reg.roof : q_reg.floor;
  assign fixed_c = q_reg.s2[dvs_pkg::SY_LVL] ? q_reg.mode[dvs_pkg::ROOF_OP_BIT]
                                             : q_reg.mode[dvs_pkg::FLOOR_OP_BIT];
  assign single_c = (q_reg.ramp[dvs_pkg::RATE_MSB:0] == dvs_pkg::RATE_SINGLE);
  always_comb begin
    if (q_reg.ramp[dvs_pkg::STRAT_BIT]) begin
      goal_c = sel_c[dvs_pkg::STEP_MSB:0];
    end else if (q_reg.ramp[dvs_pkg::TRIG_BIT]) begin
      goal_c = q_reg.roof[dvs_pkg::STEP_MSB:0];
    end else begin
      goal_c = q_reg.cur;
    end
  end

  // next state
  always_comb begin
    q_next = q_reg;
    q_next.s1 = {link_htog, link_wtog, out_low_cmp, skip_pulsing,
                 level_select_pin, chip_on_pin, sda_in, scl_in};
    q_next.s2 = q_reg.s1;
    q_next.s3 = q_reg.s2;

    // hold the link at the start of the address byte from start or stop until clock low
    if (start_c | stop_c) begin
      q_next.clr = 1'b1;
    end else if (!q_reg.s2[dvs_pkg::SY_SCL]) begin
      q_next.clr = 1'b0;
    end

    // high-speed timing until stop
    if (stop_c) begin
      q_next.hs = 1'b0;
    end else if (hs_evt) begin
      q_next.hs = 1'b1;
    end

    // ramp engine
    // drop is cleared first so a new drop in this cycle wins
    if (q_reg.s2[dvs_pkg::SY_SKIP]) begin
      q_next.drop = 1'b0;
    end
    if (goal_c == q_reg.cur) begin
      q_next.ramping = 1'b0;
      q_next.cnt = 16'h0000;
      if (!q_reg.ramp[dvs_pkg::STRAT_BIT]) begin
        q_next.ramp[dvs_pkg::TRIG_BIT] = 1'b0;
      end
    end else if (single_c) begin
      q_next.cur = goal_c;
      q_next.ramping = 1'b0;
      q_next.cnt = 16'h0000;
      if (goal_c < q_reg.cur && !fixed_c) begin
        q_next.drop = 1'b1;
      end
    end else begin
      q_next.ramping = 1'b1;
      if (q_reg.cnt >= step_cycles(q_reg.ramp[dvs_pkg::RATE_MSB:0]) - 16'h0001) begin
        q_next.cnt = 16'h0000;
        q_next.cur = (goal_c > q_reg.cur) ? q_reg.cur + 6'h01 : q_reg.cur - 6'h01;
      end else begin
        q_next.cnt = q_reg.cnt + 16'h0001;
      end
    end

    // register writes; a write beats the trigger clear
    // pointer bytes are kept even when unlisted, so reads answer ff
    if (chip_rise) begin
      q_next.floor = {dvs_pkg::VOLT_TOP_RST, FLOOR_STEP_RST};
      q_next.roof = {dvs_pkg::VOLT_TOP_RST, ROOF_STEP_RST};
      q_next.mode = dvs_pkg::MODE_RST;
      q_next.ramp = dvs_pkg::RAMP_RST;
      q_next.ptr = dvs_pkg::PTR_RST;
    end else if (wr_evt && q_reg.s2[dvs_pkg::SY_CHIP]) begin
      if (link_wptr) begin
        q_next.ptr = link_wbyte;
      end else if (q_reg.ptr[dvs_pkg::PTR_MSB:dvs_pkg::PTR_SEL_MSB+1] == '0) begin
        case (q_reg.ptr[dvs_pkg::PTR_SEL_MSB:0])
          dvs_pkg::SEL_FLOOR: begin
            q_next.floor = link_wbyte;
            q_next.roof[dvs_pkg::CONV_BIT:dvs_pkg::LIGHT_BIT] =
              link_wbyte[dvs_pkg::CONV_BIT:dvs_pkg::LIGHT_BIT];
          end
          dvs_pkg::SEL_ROOF: begin
            q_next.roof = link_wbyte;
            q_next.floor[dvs_pkg::CONV_BIT:dvs_pkg::LIGHT_BIT] =
              link_wbyte[dvs_pkg::CONV_BIT:dvs_pkg::LIGHT_BIT];
          end
          dvs_pkg::SEL_MODE: q_next.mode = link_wbyte;
          default: q_next.ramp = link_wbyte;
        endcase
      end
    end

    // registered outputs
    q_next.rd = reg_read(q_reg);
    q_next.en = q_reg.s2[dvs_pkg::SY_CHIP] & q_reg.floor[dvs_pkg::CONV_BIT];
    q_next.pg = q_reg.en & ~q_reg.ramping & ~q_reg.drop & ~q_reg.s2[dvs_pkg::SY_LOW];
    q_next.fixed = fixed_c;
    q_next.light = q_reg.floor[dvs_pkg::LIGHT_BIT];
  end

  // state register, frozen while ce is low
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      q_reg <= '0;
      q_reg.floor <= {dvs_pkg::VOLT_TOP_RST, FLOOR_STEP_RST};
      q_reg.roof <= {dvs_pkg::VOLT_TOP_RST, ROOF_STEP_RST};
      q_reg.mode <= dvs_pkg::MODE_RST;
      q_reg.ramp <= dvs_pkg::RAMP_RST;
      q_reg.s1 <= 8'h03;
      q_reg.s2 <= 8'h03;
      q_reg.s3 <= 8'h03;
      q_reg.clr <= 1'b1;
    end else if (ce) begin
      q_reg <= q_next;
    end
  end

  // pins and outputs
  assign sda_out = 1'b0;
  assign sda_oe_n = ~link_drv;
  assign output_good = q_reg.pg;
  assign converter_en = q_reg.en;
  assign vout_code = q_reg.cur;
  assign light_skip_optimize = q_reg.light;
  assign forced_fixed = q_reg.fixed;
  assign hs_mode = q_reg.hs;

  // checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  sequence single_drop_s;
    ce && single_c && goal_c < q_reg.cur;
  endsequence

  sequence hs_stop_s;
    ce && stop_c;
  endsequence

  unmapped_read_a: assert property (
    ce && q_reg.ptr[dvs_pkg::PTR_MSB:dvs_pkg::PTR_SEL_MSB+1] != '0 |=> q_reg.rd == dvs_pkg::RD_UNMAPPED)
    else $error("unlisted register read not ff");
  hs_exit_a: assert property (hs_stop_s |=> !hs_mode)
    else $error("high-speed kept after stop");
  chip_reset_a: assert property (
    ce && chip_rise |=> q_reg.ramp == dvs_pkg::RAMP_RST && q_reg.mode == dvs_pkg::MODE_RST)
    else $error("defaults not restored");
  off_ignore_a: assert property (
    ce && wr_evt && !q_reg.s2[dvs_pkg::SY_CHIP] |=> $stable(q_reg.floor) && $stable(q_reg.mode))
    else $error("update while chip off");
  shared_bits_a: assert property (
    q_reg.floor[dvs_pkg::CONV_BIT:dvs_pkg::LIGHT_BIT] == q_reg.roof[dvs_pkg::CONV_BIT:dvs_pkg::LIGHT_BIT])
    else $error("shared bits differ");
  ramp_pg_a: assert property (ce && q_reg.ramping |=> !output_good)
    else $error("output good while ramping");
  single_up_a: assert property (
    ce && single_c && goal_c > q_reg.cur |=> vout_code == $past(goal_c))
    else $error("single step up not immediate");
  fixed_down_a: assert property (
    single_drop_s ##0 fixed_c |=> vout_code == $past(goal_c) && (!q_reg.drop || $past(q_reg.drop)))
    else $error("fixed downward not immediate");
  skip_hold_a: assert property (
    single_drop_s ##0 !fixed_c |=> q_reg.drop ##1 !output_good)
    else $error("output good during skip drop");
  micro_step_a: assert property (
    ce && !single_c |=> vout_code == $past(vout_code) || vout_code == $past(vout_code) + 6'h01
      || vout_code == $past(vout_code) - 6'h01)
    else $error("micro-step larger than one code");
  hw_select_a: assert property (
    ce && single_c && q_reg.ramp[dvs_pkg::STRAT_BIT] && q_reg.s2[dvs_pkg::SY_LVL]
      |=> vout_code == $past(q_reg.roof[dvs_pkg::STEP_MSB:0]))
    else $error("roof not applied with pin high");
  trig_clear_a: assert property (
    ce && !wr_evt && !chip_rise && q_reg.ramp[dvs_pkg::TRIG_BIT] && !q_reg.ramp[dvs_pkg::STRAT_BIT]
      && q_reg.cur == q_reg.roof[dvs_pkg::STEP_MSB:0] |=> !q_reg.ramp[dvs_pkg::TRIG_BIT])
    else $error("trigger not cleared at target");

  // outputs, selection and register side effects
  low_good_a: assert property (ce && q_reg.s2[dvs_pkg::SY_LOW] |=> !output_good)
    else $error("output good with output low");
  off_good_a: assert property (ce && !converter_en |=> !output_good)
    else $error("output good while converter off");
  conv_gate_a: assert property (ce && !q_reg.s2[dvs_pkg::SY_CHIP] |=> !converter_en)
    else $error("converter on with chip-on low");
  floor_mode_a: assert property (
    ce && !q_reg.s2[dvs_pkg::SY_LVL] |=> forced_fixed == $past(q_reg.mode[dvs_pkg::FLOOR_OP_BIT]))
    else $error("floor operating mode not applied");
  roof_mode_a: assert property (
    ce && q_reg.s2[dvs_pkg::SY_LVL] |=> forced_fixed == $past(q_reg.mode[dvs_pkg::ROOF_OP_BIT]))
    else $error("roof operating mode not applied");
  ptr_write_a: assert property (
    ce && wr_evt && link_wptr && q_reg.s2[dvs_pkg::SY_CHIP] && !chip_rise |=> q_reg.ptr == $past(link_wbyte))
    else $error("register address not taken");
  multi_ramp_a: assert property (ce && !single_c && goal_c != q_reg.cur |=> q_reg.ramping)
    else $error("multiple step not ramping");
  single_flat_a: assert property (ce && single_c |=> !q_reg.ramping)
    else $error("single step left ramping");
  sw_ignore_a: assert property (
    ce && !q_reg.ramp[dvs_pkg::STRAT_BIT] && !q_reg.ramp[dvs_pkg::TRIG_BIT] |=> $stable(vout_code))
    else $error("output moved without trigger");
  volt_reset_a: assert property (
    ce && chip_rise |=> q_reg.floor == {dvs_pkg::VOLT_TOP_RST, FLOOR_STEP_RST}
      && q_reg.roof == {dvs_pkg::VOLT_TOP_RST, ROOF_STEP_RST})
    else $error("voltage defaults not restored");
  light_out_a: assert property (ce |=> light_skip_optimize == $past(q_reg.roof[dvs_pkg::LIGHT_BIT]))
    else $error("light skip tuning not shared");
  unsel_keep_a: assert property (
    ce && single_c && q_reg.ramp[dvs_pkg::STRAT_BIT] && !q_reg.s2[dvs_pkg::SY_LVL]
      && q_reg.cur == q_reg.floor[dvs_pkg::STEP_MSB:0] |=> $stable(vout_code))
    else $error("unselected write moved output");
endmodule // dvs_register_ctrl
`default_nettype wire

/* verification/dvs_i2c_host.sv */
`timescale 1ns/10ps
`default_nettype none
module dvs_i2c_host (
  output logic scl, // serial clock, stands high between frames
  output logic sda_drv, // data drive, 1 releases to pull-up
  input wire logic sda // resolved data line
);
  localparam int HALF = 32; // half of the 64 ns link period
  // idle bus: clock high, data released
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // start or repeated start; repeated start keeps fast timing
  task automatic start();
    sda_drv = 1'b1;
    #(HALF/2) scl = 1'b1;
    #HALF sda_drv = 1'b0;
    #HALF scl = 1'b0;
  endtask
  // one clock: data set while low, sampled mid high
  task automatic bit_io(input logic b, output logic s);
    sda_drv = b;
    #(HALF/2) scl = 1'b1;
    #(HALF/2) s = sda;
    #(HALF/2) scl = 1'b0;
    #(HALF/2);
  endtask
  // byte out msb first, ack bit returned
  task automatic wbyte(input logic [7:0] d, output logic ack_n);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, ack_n);
  endtask
  // byte in msb first, then master ack or nack
  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(nack, s);
  endtask
  // stop: data rises while clock high
  task automatic stop();
    sda_drv = 1'b0;
    #(HALF/2) scl = 1'b1;
    #HALF sda_drv = 1'b1;
    #HALF;
  endtask
endmodule // dvs_i2c_host
`default_nettype wire

/* verification/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam logic [6:0] DEV = {dvs_pkg::SLAVE_UPPER, 2'h0};
  logic mclk, nrst, chip_on, lvl, skip, low_cmp;
  logic sda_out, sda_oe_n, output_good, converter_en, light, fixed, hs_mode;
  logic scl, sda_drv;
  logic [5:0] vout_code;
  wire logic sda;
  int error_cnt = 0;
  int n_tests = 0;
  // open-drain data line with pull-up
  assign sda = sda_drv & (sda_oe_n ? 1'b1 : sda_out);
  dvs_i2c_host host (.scl(scl), .sda_drv(sda_drv), .sda(sda));
  dvs_register_ctrl #(.ADDR_OPTION(2'h0), .FLOOR_STEP_RST(6'h05), .ROOF_STEP_RST(6'h0a),
    .STEP_BASE_CYC(16'h0002)) DUT (
    .mclk(mclk), .nrst(nrst), .ce(1'b1), .scl_clk(scl), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .chip_on_pin(chip_on), .level_select_pin(lvl),
    .skip_pulsing(skip), .out_low_cmp(low_cmp), .output_good(output_good),
    .converter_en(converter_en), .vout_code(vout_code), .light_skip_optimize(light),
    .forced_fixed(fixed), .hs_mode(hs_mode));
  // 125 MHz system clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic finish_test();
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // keep link edges off the system clock edges
  task automatic align();
    @(negedge mclk);
    #3;
  endtask
  task automatic wr(input logic [7:0] ra, input logic [7:0] d);
    logic a0, a1, a2;
    align();
    host.start();
    host.wbyte({DEV, 1'b0}, a0);
    host.wbyte(ra, a1);
    host.wbyte(d, a2);
    host.stop();
    chk("wr ack", 8'h00, {5'h0, a0, a1, a2});
    #200;
  endtask
  task automatic rchk(input string what, input logic [7:0] ra, input logic [7:0] exp);
    logic a0, a1, a2;
    logic [7:0] d;
    align();
    host.start();
    host.wbyte({DEV, 1'b0}, a0);
    host.wbyte(ra, a1);
    host.start();
    host.wbyte({DEV, 1'b1}, a2);
    host.rbyte(1'b1, d);
    host.stop();
    chk("rd ack", 8'h00, {5'h0, a0, a1, a2});
    chk(what, exp, d);
    #200;
  endtask
  task automatic wait_vout(input logic [5:0] exp, output int n);
    n = 0;
    while (vout_code !== exp && n < 1000) begin
      @(negedge mclk);
      n++;
    end
    chk("vout reached", 8'(exp), 8'(vout_code));
  endtask
  task automatic t_reset();
    rchk("floor", 8'h00, 8'hc5);
    rchk("roof", 8'h01, 8'hca);
    rchk("mode", 8'h02, 8'h00);
    rchk("ramp", 8'h03, 8'h17);
    chk("vout", 8'h05, 8'(vout_code));
    chk("light", 8'h01, 8'(light));
    chk("good", 8'h01, 8'(output_good));
  endtask
  task automatic t_good();
    @(posedge mclk) low_cmp <= 1'b1;
    settle(6);
    chk("low out", 8'h00, 8'(output_good));
    @(posedge mclk) low_cmp <= 1'b0;
    settle(6);
    chk("good back", 8'h01, 8'(output_good));
  endtask
  task automatic t_bus();
    logic a;
    align();
    host.start();
    host.wbyte({dvs_pkg::SLAVE_UPPER, 2'h1, 1'b0}, a);
    host.stop();
    chk("foreign nack", 8'h01, 8'(a));
    align();
    host.start();
    host.wbyte(8'h08, a);
    settle(6);
    chk("hs nack", 8'h01, 8'(a));
    chk("hs on", 8'h01, 8'(hs_mode));
    host.start();
    host.wbyte({DEV, 1'b0}, a);
    settle(6);
    chk("hs ack", 8'h00, 8'(a));
    chk("hs kept", 8'h01, 8'(hs_mode));
    host.stop();
    settle(6);
    chk("hs off", 8'h00, 8'(hs_mode));
    rchk("unlisted", 8'h04, 8'hff);
    rchk("upper bits", 8'h81, 8'hff);
    wr(8'h40, 8'h00);
    rchk("floor kept", 8'h00, 8'hc5);
  endtask
  task automatic t_hw();
    wr(8'h01, 8'hcc);
    chk("unselected", 8'h05, 8'(vout_code));
    @(posedge mclk) lvl <= 1'b1;
    settle(8);
    chk("roof sel", 8'h0c, 8'(vout_code));
    chk("roof op", 8'h00, 8'(fixed));
    wr(8'h01, 8'hce);
    chk("selected", 8'h0e, 8'(vout_code));
    wr(8'h02, 8'h01);
    @(posedge mclk) lvl <= 1'b0;
    settle(8);
    chk("fixed down", 8'h05, 8'(vout_code));
    chk("floor op", 8'h01, 8'(fixed));
    chk("fixed good", 8'h01, 8'(output_good));
  endtask
  task automatic t_skip();
    wr(8'h02, 8'h00);
    @(posedge mclk) lvl <= 1'b1;
    settle(8);
    @(posedge mclk) skip <= 1'b0;
    @(posedge mclk) lvl <= 1'b0;
    settle(50);
    chk("skip vout", 8'h05, 8'(vout_code));
    chk("skip good", 8'h00, 8'(output_good));
    @(posedge mclk) skip <= 1'b1;
    settle(8);
    chk("resumed", 8'h01, 8'(output_good));
  endtask
  task automatic t_ramp();
    int n;
    for (int r = 0; r < 7; r++) begin
      wr(8'h03, {5'h02, 3'(r)});
      wr(8'h00, (r % 2) ? 8'hc9 : 8'hc7);
      wait_vout((r % 2) ? 6'h09 : 6'h07, n);
    end
    wr(8'h00, 8'hcb);
    chk("ramping good", 8'h00, 8'(output_good));
    chk("ramping", 8'h01, 8'(vout_code < 6'h0b));
    wait_vout(6'h0b, n);
    chk("ramp span", 8'h01, 8'(n > 250));
    settle(4);
    chk("ramp good", 8'h01, 8'(output_good));
  endtask
  task automatic t_sw();
    wr(8'h03, 8'h07);
    wr(8'h01, 8'hd0);
    @(posedge mclk) lvl <= 1'b1;
    settle(8);
    chk("sw hold", 8'h0b, 8'(vout_code));
    wr(8'h03, 8'h87);
    chk("sw go", 8'h10, 8'(vout_code));
    rchk("go clear", 8'h03, 8'h07);
  endtask
  task automatic t_conv();
    wr(8'h00, 8'h45);
    rchk("roof map", 8'h01, 8'h50);
    chk("conv off", 8'h00, 8'(converter_en));
    chk("off good", 8'h00, 8'(output_good));
    wr(8'h01, 8'h90);
    rchk("floor map", 8'h00, 8'h85);
    chk("conv on", 8'h01, 8'(converter_en));
    chk("light off", 8'h00, 8'(light));
  endtask
  task automatic t_chip();
    wr(8'h03, 8'h17);
    @(posedge mclk) lvl <= 1'b0;
    @(posedge mclk) chip_on <= 1'b0;
    settle(8);
    chk("chip off", 8'h00, 8'(converter_en));
    wr(8'h00, 8'hc2);
    chk("no update", 8'h05, 8'(vout_code));
    @(posedge mclk) chip_on <= 1'b1;
    settle(8);
    rchk("floor dflt", 8'h00, 8'hc5);
    rchk("roof dflt", 8'h01, 8'hca);
    rchk("ramp dflt", 8'h03, 8'h17);
  endtask
  // main sequence
  initial begin
    nrst = 1'b0;
    chip_on = 1'b1;
    lvl = 1'b0;
    skip = 1'b1;
    low_cmp = 1'b0;
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    repeat (12) @(posedge mclk);
    t_reset();
    t_good();
    t_bus();
    t_hw();
    t_skip();
    t_ramp();
    t_sw();
    t_conv();
    t_chip();
    finish_test();
  end
  // watchdog against a hung handshake
  initial begin
    #600000;
    error_cnt++;
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
